/* verilog/frsf_pkg.sv */
// Constants for the floppy result status flag block
// Behaviour
// - Set end-of-cylinder on access past last sector
// - Set end-of-cylinder when data command lacks count
// - Set data error on ID or data CRC
// - Set overrun flag on late byte service
// - Set no-data when read sector or read-track start missing
// - Set no-data on read-ID field error
// - Set not-writeable on protected disk writes
// - Set missing address mark when no data mark
// - Set missing address mark after two index pulses
// - Set control mark on deleted mark in read
// - Set control mark on normal mark in read-deleted
// - Set data-field CRC flag on data CRC
// - Set wrong cylinder on track mismatch
// - Set scan hit on equal scan condition
// - Set scan not satisfied when nothing qualifies
// - Set bad cylinder when ID track FFh mismatches
// - Set missing data mark when no mark found
// - Bytes read-only, report latest result command
package frsf_pkg;
    // ---------------------------------------------
    // Transfer error status bit positions
    // ---------------------------------------------
    localparam int TES_END_CYL = 7;
    localparam int TES_DATA_ERR = 5;
    localparam int TES_OVERRUN = 4;
    localparam int TES_NO_DATA = 2;
    localparam int TES_NOT_WR = 1;
    localparam int TES_MISS_AM = 0;
    // ---------------------------------------------
    // Data field status bit positions
    // ---------------------------------------------
    localparam int DFS_CTRL_MARK = 6;
    localparam int DFS_CRC_ERR = 5;
    localparam int DFS_WRONG_CYL = 4;
    localparam int DFS_SCAN_HIT = 3;
    localparam int DFS_SCAN_NS = 2;
    localparam int DFS_BAD_CYL = 1;
    localparam int DFS_MISS_DM = 0;
    // ---------------------------------------------
    // Reset values, masks and constants
    // ---------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] TES_USED_MASK = 8'hb7;
    localparam logic [7:0] DFS_USED_MASK = 8'h7f;
    localparam logic [7:0] BAD_TRACK = 8'hff;
    localparam logic [1:0] INDEX_LIMIT = 2'h2;
    typedef enum logic [2:0] {
        FRSF_CMD_OTHER,
        FRSF_CMD_READ,
        FRSF_CMD_READ_DEL,
        FRSF_CMD_WRITE,
        FRSF_CMD_WRITE_DEL,
        FRSF_CMD_FORMAT,
        FRSF_CMD_READ_ID,
        FRSF_CMD_READ_TRACK
    } frsf_cmd_t;
endpackage : frsf_pkg

/* verilog/frsf_index_counter.sv */
// Counts index pulses while an ID mark is being searched for
module frsf_index_counter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic index_seen,
    input wire logic id_found,
    output logic limit_hit
);
    import frsf_pkg::*;
    logic [1:0] count_q;
    logic hit_q;

    // ---------------------------------------------
    // Index pulse counting
    // ---------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n || restart || id_found) begin
            count_q <= 2'h0;
        end else if (index_seen && count_q != INDEX_LIMIT) begin
            count_q <= count_q + 2'h1;
        end
    end

    // One pulse on reaching the second index
    always_ff @(posedge clock) begin
        if (!rst_n || restart || id_found) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= index_seen && count_q == INDEX_LIMIT - 2'h1;
        end
    end

    assign limit_hit = hit_q;
endmodule : frsf_index_counter

/* verilog/frsf_status_flags.sv */
// Second and third result status bytes of the floppy controller
module frsf_status_flags (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_accept,
    input wire frsf_pkg::frsf_cmd_t cmd_kind,
    input wire logic scan_cmd,
    input wire logic sector_past_eot,
    input wire logic xfer_done,
    input wire logic terminal_count,
    input wire logic id_crc_err,
    input wire logic data_crc_err,
    input wire logic service_late,
    input wire logic sector_not_found,
    input wire logic start_not_found,
    input wire logic id_read_err,
    input wire logic write_protect_pin,
    input wire logic write_attempt,
    input wire logic data_mark_missing,
    input wire logic index_pin_n,
    input wire logic id_search,
    input wire logic id_found,
    input wire logic deleted_mark_found,
    input wire logic normal_mark_found,
    input wire logic [7:0] id_track,
    input wire logic [7:0] cur_track,
    input wire logic id_check,
    input wire logic scan_equal,
    input wire logic scan_none,
    output logic [7:0] transfer_error_status,
    output logic [7:0] data_field_status
);
    import frsf_pkg::*;

    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    logic wp_meta_q;
    logic wp_q;
    logic idx_meta_q;
    logic idx_q;
    logic idx_prev_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wp_meta_q <= 1'b0;
            wp_q <= 1'b0;
            idx_meta_q <= 1'b1;
            idx_q <= 1'b1;
            idx_prev_q <= 1'b1;
        end else begin
            wp_meta_q <= write_protect_pin;
            wp_q <= wp_meta_q;
            idx_meta_q <= index_pin_n;
            idx_q <= idx_meta_q;
            idx_prev_q <= idx_q;
        end
    end

    // Falling edge of the active-low index input
    logic index_seen;
    assign index_seen = idx_prev_q && !idx_q;

    // ---------------------------------------------
    // Command tracking
    // ---------------------------------------------
    frsf_cmd_t cmd_q;
    logic tc_seen_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_q <= FRSF_CMD_OTHER;
        end else if (cmd_accept) begin
            cmd_q <= cmd_kind;
        end
    end

    // Terminal count remembered over the transfer
    always_ff @(posedge clock) begin
        if (!rst_n || cmd_accept) begin
            tc_seen_q <= 1'b0;
        end else if (terminal_count) begin
            tc_seen_q <= 1'b1;
        end
    end

    logic two_index;
    frsf_index_counter u_index (
        .clock(clock),
        .rst_n(rst_n),
        .restart(cmd_accept || !id_search),
        .index_seen(index_seen && id_search),
        .id_found(id_found),
        .limit_hit(two_index)
    );

    // ---------------------------------------------
    // Event decoding
    // ---------------------------------------------
    logic is_read;
    logic is_write;
    logic data_cmd;
    logic tc_this;
    logic mismatch;
    assign is_read = cmd_q == FRSF_CMD_READ;
    assign is_write = cmd_q == FRSF_CMD_WRITE || cmd_q == FRSF_CMD_WRITE_DEL
        || cmd_q == FRSF_CMD_FORMAT;
    assign data_cmd = is_read || cmd_q == FRSF_CMD_WRITE;
    assign tc_this = tc_seen_q || terminal_count;
    assign mismatch = id_check && id_track != cur_track;

    logic [7:0] tes_set;
    logic [7:0] dfs_set;
    always_comb begin
        tes_set = 8'h00;
        dfs_set = 8'h00;
        tes_set[TES_END_CYL] = sector_past_eot;
        if (xfer_done && data_cmd && !tc_this) begin
            tes_set[TES_END_CYL] = 1'b1;
        end
        tes_set[TES_DATA_ERR] = id_crc_err || data_crc_err;
        tes_set[TES_OVERRUN] = service_late;
        tes_set[TES_NO_DATA] = (sector_not_found
            && (is_read || cmd_q == FRSF_CMD_READ_DEL))
            || (start_not_found && cmd_q == FRSF_CMD_READ_TRACK);
        if (id_read_err && cmd_q == FRSF_CMD_READ_ID) begin
            tes_set[TES_NO_DATA] = 1'b1;
        end
        tes_set[TES_NOT_WR] = write_attempt && is_write && wp_q;
        tes_set[TES_MISS_AM] = data_mark_missing || two_index;
        dfs_set[DFS_CTRL_MARK] = (deleted_mark_found && is_read)
            || (normal_mark_found && cmd_q == FRSF_CMD_READ_DEL);
        dfs_set[DFS_CRC_ERR] = data_crc_err;
        dfs_set[DFS_WRONG_CYL] = mismatch;
        dfs_set[DFS_SCAN_HIT] = scan_cmd && scan_equal;
        dfs_set[DFS_SCAN_NS] = scan_cmd && scan_none;
        dfs_set[DFS_BAD_CYL] = mismatch && id_track == BAD_TRACK;
        dfs_set[DFS_MISS_DM] = data_mark_missing;
    end

    // ---------------------------------------------
    // Sticky status bytes
    // ---------------------------------------------
    logic [7:0] tes_q;
    logic [7:0] dfs_q;
    // clear on accept
    // Set wins over clear so a same-cycle event is kept
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tes_q <= STATUS_RESET;
        end else if (cmd_accept) begin
            tes_q <= tes_set & TES_USED_MASK;
        end else begin
            tes_q <= (tes_q | tes_set) & TES_USED_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dfs_q <= STATUS_RESET;
        end else if (cmd_accept) begin
            dfs_q <= dfs_set & DFS_USED_MASK;
        end else begin
            dfs_q <= (dfs_q | dfs_set) & DFS_USED_MASK;
        end
    end

    assign transfer_error_status = tes_q;
    assign data_field_status = dfs_q;
endmodule : frsf_status_flags

/* verification/frsf_status_flags_sva.sv */
// Checker for the result status flag outputs
module frsf_status_flags_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_accept,
    input wire logic sector_past_eot,
    input wire logic data_crc_err,
    input wire logic service_late,
    input wire logic data_mark_missing,
    input wire logic id_check,
    input wire logic [7:0] id_track,
    input wire logic [7:0] cur_track,
    input wire logic [7:0] transfer_error_status,
    input wire logic [7:0] data_field_status
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tes;
    logic [7:0] dfs;
    assign tes = transfer_error_status;
    assign dfs = data_field_status;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_mismatch;
        id_check && id_track != cur_track;
    endsequence
    a_eot_flag: assert property (sector_past_eot |=> tes[7])
        else $error("end of cylinder not set");
    a_crc_flags: assert property (data_crc_err |=> tes[5] && dfs[5])
        else $error("crc flags not set");
    a_late_flag: assert property (service_late |=> tes[4])
        else $error("overrun not set");
    a_mark_flags: assert property (data_mark_missing |=> tes[0] && dfs[0])
        else $error("mark flags not set");
    a_wrong_cyl: assert property (s_mismatch |=> dfs[4])
        else $error("wrong cylinder not set");
    a_bad_cyl: assert property (s_mismatch ##0 id_track == 8'hff |=> dfs[1])
        else $error("bad cylinder not set");
    a_flags_sticky: assert property (!cmd_accept |=>
        ($past(tes) & ~tes) == 8'h00 && ($past(dfs) & ~dfs) == 8'h00)
        else $error("flag dropped without accept");
    a_clear_accept: assert property (cmd_accept && !service_late |=> !tes[4])
        else $error("flag not cleared on accept");
    a_unused_zero: assert property ({tes[6], tes[3], dfs[7]} == 3'h0)
        else $error("unused bit set");
endmodule : frsf_status_flags_chk

bind frsf_status_flags frsf_status_flags_chk chk_u (.clock(clock), .rst_n(rst_n),
    .cmd_accept(cmd_accept), .sector_past_eot(sector_past_eot), .data_crc_err(data_crc_err),
    .service_late(service_late), .data_mark_missing(data_mark_missing), .id_check(id_check),
    .id_track(id_track), .cur_track(cur_track), .transfer_error_status(transfer_error_status),
    .data_field_status(data_field_status));

/* verification/frsf_host_model.sv */
// Host model that collects both result bytes
module frsf_host_model (
    input wire logic clock,
    input wire logic result_phase,
    input wire logic [7:0] transfer_error_status,
    input wire logic [7:0] data_field_status,
    output logic [15:0] result_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic request_for_master;
    logic transfer_direction_bit;
    assign request_for_master = result_phase;
    assign transfer_direction_bit = result_phase;
    always_ff @(posedge clock) begin
        if (request_for_master && transfer_direction_bit) begin
            result_q <= {transfer_error_status, data_field_status};
        end
    end
endmodule : frsf_host_model

/* verification/testbench.sv */
// Self-checking bench for the result status flag block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import frsf_pkg::*;
    logic clock = 0, rst_n = 0, rd = 0, wp_pin = 1, idx_n = 1, id_search = 0, scan_cmd = 1;
    logic [17:0] ev = 0;
    logic [7:0] id_trk = 8'h07, cur_trk = 8'h03, tes, dfs;
    logic [15:0] res;
    frsf_cmd_t kind = FRSF_CMD_OTHER;
    int error_cnt = 0, samples_checked = 0;
    always #2.5 clock = ~clock;
    frsf_status_flags dut_u (.clock(clock), .rst_n(rst_n), .cmd_accept(ev[0]), .cmd_kind(kind),
        .scan_cmd(scan_cmd), .sector_past_eot(ev[1]), .xfer_done(ev[2]), .terminal_count(ev[3]),
        .id_crc_err(ev[4]), .data_crc_err(ev[5]), .service_late(ev[6]),
        .sector_not_found(ev[7]), .start_not_found(ev[8]), .id_read_err(ev[9]),
        .write_protect_pin(wp_pin), .write_attempt(ev[10]), .data_mark_missing(ev[11]),
        .index_pin_n(idx_n), .id_search(id_search), .id_found(ev[12]),
        .deleted_mark_found(ev[13]), .normal_mark_found(ev[14]), .id_track(id_trk),
        .cur_track(cur_trk), .id_check(ev[15]), .scan_equal(ev[16]), .scan_none(ev[17]),
        .transfer_error_status(tes), .data_field_status(dfs));
    frsf_host_model host_u (.clock(clock), .result_phase(rd), .transfer_error_status(tes),
        .data_field_status(dfs), .result_q(res));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task fire(input logic [17:0] m);
        ev = m;
        @(posedge clock) #1;
    endtask : fire
    task run(input frsf_cmd_t k, input logic [17:0] m1, m2, input logic [15:0] exp);
        kind = k;
        fire(18'h1);
        chk({tes, dfs}, 16'h0000);
        fire(m1);
        fire(m2);
        rd = 1;
        ev = 0;
        @(posedge clock) #1;
        rd = 0;
        chk(res, exp);
        $display("test done exp=%h", exp);
    endtask : run
    task complete_run;
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // ----------------------------
    // Test sequence
    // ----------------------------
    initial begin
        repeat (16) @(posedge clock);
        #1 rst_n = 1;
        run(FRSF_CMD_OTHER, 18'h2, 18'h0, 16'h8000);
        run(FRSF_CMD_READ, 18'h4, 18'h0, 16'h8000);
        run(FRSF_CMD_WRITE, 18'h8, 18'h4, 16'h0000);
        run(FRSF_CMD_OTHER, 18'h10, 18'h0, 16'h2000);
        run(FRSF_CMD_READ, 18'h20, 18'h0, 16'h2020);
        run(FRSF_CMD_OTHER, 18'h40, 18'h800, 16'h1101);
        run(FRSF_CMD_READ, 18'h80, 18'h0, 16'h0400);
        run(FRSF_CMD_READ_DEL, 18'h80, 18'h0, 16'h0400);
        run(FRSF_CMD_WRITE, 18'h80, 18'h0, 16'h0000);
        run(FRSF_CMD_READ_TRACK, 18'h100, 18'h0, 16'h0400);
        run(FRSF_CMD_READ_ID, 18'h200, 18'h0, 16'h0400);
        run(FRSF_CMD_WRITE, 18'h400, 18'h0, 16'h0200);
        run(FRSF_CMD_WRITE_DEL, 18'h400, 18'h0, 16'h0200);
        run(FRSF_CMD_FORMAT, 18'h400, 18'h0, 16'h0200);
        run(FRSF_CMD_READ, 18'h400, 18'h0, 16'h0000);
        run(FRSF_CMD_READ, 18'h2000, 18'h0, 16'h0040);
        run(FRSF_CMD_READ_DEL, 18'h4000, 18'h0, 16'h0040);
        run(FRSF_CMD_READ_DEL, 18'h2000, 18'h0, 16'h0000);
        run(FRSF_CMD_OTHER, 18'h8000, 18'h0, 16'h0010);
        id_trk = 8'hff;
        run(FRSF_CMD_OTHER, 18'h8000, 18'h0, 16'h0012);
        run(FRSF_CMD_OTHER, 18'h10000, 18'h20000, 16'h000c);
        // Scan outcomes ignored outside a scan command
        scan_cmd = 0;
        run(FRSF_CMD_OTHER, 18'h10000, 18'h20000, 16'h0000);
        // Unprotected disk: write attempt after sync delay leaves flag clear
        wp_pin = 0;
        run(FRSF_CMD_WRITE, 18'h0, 18'h400, 16'h0000);
        wp_pin = 1;
        kind = FRSF_CMD_READ;
        fire(18'h1);
        id_search = 1;
        for (int i = 0; i < 4; i++) begin
            idx_n = ~idx_n;
            repeat (3) fire(18'h0);
        end
        chk({tes, dfs}, 16'h0100);
        $display("test done index");
        complete_run;
    end
    // Span far beyond the expected run of about 120 cycles
    initial begin
        #40000;
        error_cnt++;
        complete_run;
    end
endmodule : testbench
